// ---- logic/dpmc_core.v ----
`timescale 1ns/1ps
`include "dpmc_defs.vh"

// Notes on behaviour
// - Input pre-scaler is an 8-bit integer divider, ratios 1 to 255.
// - First-loop feedback divider is 15-bit, ratios 4 to 32767.
// - Each VCO has an 8-bit feedback divider, ratios 8 to 255.
// - Three banks each pick one of 18 output ratios from 1 to 96.
// - Sysref rate divider offers 10 values, 64 to 2048, off the VCO.
// - Up to four sysref outputs, each periodic or a finite pulse burst.
// - Each sysref output may instead act as an ordinary clock output.
// - Each bank has its own programmable phase delay.
// - Bypass 1 feeds input straight to second loop and stops monitoring.
// - No input activity for a fixed time sets the loss flag.
// - Hold-over entered on signal loss or hold bit written 1.
// - In hold-over the oscillator control is parked at half supply.
// - Pump current is a 6-bit code, 64 steps of 20 uA.
// - Configuration is eight 32-bit words written over SPI.
// - The host can read back every configuration word.
// - Cleaned first-loop clock goes to its own dedicated output.
// - A fault status pin reports loss of signal to the system.
module dpmc_core #(
  parameter LOS_CYCLES = `DPMC_LOS_TIME_NS / `DPMC_CLK_NS
) (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire        spi_sck,
  input  wire        spi_mosi,
  input  wire        spi_le_b,
  output wire        spi_miso,
  input  wire        ref_clk_in,
  input  wire        vcxo_clk_in,
  output reg  [7:0]  prescale_div,
  output reg  [14:0] loop1_fb_div,
  output reg  [7:0]  vco0_feedback_div,
  output reg  [7:0]  vco1_feedback_div,
  output reg         vco_select,
  output reg  [6:0]  bank_a_div,
  output reg  [6:0]  bank_b_div,
  output reg  [6:0]  bank_c_div,
  output reg  [11:0] sysref_div,
  output reg  [5:0]  bank_a_phase,
  output reg  [5:0]  bank_b_phase,
  output reg  [5:0]  bank_c_phase,
  output reg  [3:0]  sysref_out_en,
  output reg  [3:0]  sysref_periodic,
  output reg  [3:0]  sysref_as_clock,
  output reg  [3:0]  sysref_pulse_cnt,
  output reg         loop2_ref_is_input,
  output reg         cleaned_ref_out_en,
  output reg         holdover_active,
  output reg         vctrl_park_mid,
  output reg  [5:0]  pump_current_code,
  output reg  [10:0] pump_current_ua,
  output reg         signal_loss_flag,
  output reg         fault_status_pin_b
);
  localparam [31:0] LOS_N = LOS_CYCLES;

  reg  [31:0] cfg_q [0:`DPMC_NWORDS-1];
  reg  [2:0]  ref_s_q;
  reg  [31:0] idle_cnt_q;
  reg         input_signal_lost;
  integer     i;

  wire        wr_stb;
  wire [2:0]  wr_idx;
  wire [31:0] wr_data;
  wire [2:0]  rd_idx;

  // Output divider code to ratio, 18 entries
  function [6:0] bank_ratio;
    input [4:0] code;
    begin
      case (code)
        5'h00: bank_ratio = 7'h01;
        5'h01: bank_ratio = 7'h02;
        5'h02: bank_ratio = 7'h03;
        5'h03: bank_ratio = 7'h04;
        5'h04: bank_ratio = 7'h05;
        5'h05: bank_ratio = 7'h06;
        5'h06: bank_ratio = 7'h08;
        5'h07: bank_ratio = 7'h0a;
        5'h08: bank_ratio = 7'h0c;
        5'h09: bank_ratio = 7'h10;
        5'h0a: bank_ratio = 7'h14;
        5'h0b: bank_ratio = 7'h18;
        5'h0c: bank_ratio = 7'h20;
        5'h0d: bank_ratio = 7'h28;
        5'h0e: bank_ratio = 7'h30;
        5'h0f: bank_ratio = 7'h40;
        5'h10: bank_ratio = 7'h50;
        5'h11: bank_ratio = 7'h60;
        default: bank_ratio = 7'h01;
      endcase
    end
  endfunction

  // Sysref code to ratio, 10 entries
  function [11:0] sref_ratio;
    input [3:0] code;
    begin
      case (code)
        4'h0: sref_ratio = 12'h040;
        4'h1: sref_ratio = 12'h080;
        4'h2: sref_ratio = 12'h0c0;
        4'h3: sref_ratio = 12'h100;
        4'h4: sref_ratio = 12'h180;
        4'h5: sref_ratio = 12'h200;
        4'h6: sref_ratio = 12'h300;
        4'h7: sref_ratio = 12'h400;
        4'h8: sref_ratio = 12'h600;
        4'h9: sref_ratio = 12'h800;
        default: sref_ratio = 12'h040;
      endcase
    end
  endfunction

  // Clamp an 8-bit divider to its lower bound
  function [7:0] clamp8;
    input [7:0] v;
    input [7:0] lo;
    begin
      clamp8 = (v < lo) ? lo : v;
    end
  endfunction

  dpmc_spi_slave u_spi (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .sck     (spi_sck),
    .mosi    (spi_mosi),
    .le_b    (spi_le_b),
    .rd_data (cfg_q[rd_idx]),
    .miso    (spi_miso),
    .wr_stb  (wr_stb),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .rd_idx  (rd_idx)
  );

  // Eight configuration words, all readable by the host
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < `DPMC_NWORDS; i = i + 1) begin
        cfg_q[i] <= `DPMC_RST_ZERO;
      end
      cfg_q[`DPMC_W_LOOP1] <= `DPMC_RST_LOOP1;
      cfg_q[`DPMC_W_LOOP2] <= `DPMC_RST_LOOP2;
    end else if (wr_stb) begin
      cfg_q[wr_idx] <= wr_data;
    end
  end

  // Reference pin is async; two stages then an edge detect
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ref_s_q <= 3'h0;
    end else begin
      ref_s_q <= {ref_s_q[1:0], ref_clk_in};
    end
  end

  // Activity watchdog; the flag is sticky until the host clears it.
  // A live loss wins over a clear so a fresh loss is never missed.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt_q        <= 32'h0000_0000;
      input_signal_lost <= 1'b0;
      signal_loss_flag  <= 1'b0;
    end else begin
      if (cfg_q[`DPMC_W_CTRL][`DPMC_BYPASS_BIT]) begin
        idle_cnt_q        <= 32'h0000_0000;
        input_signal_lost <= 1'b0;
      end else if (ref_s_q[1] != ref_s_q[2]) begin
        idle_cnt_q        <= 32'h0000_0000;
        input_signal_lost <= 1'b0;
      end else if (idle_cnt_q >= LOS_N - 32'h1) begin
        input_signal_lost <= 1'b1;
      end else begin
        idle_cnt_q <= idle_cnt_q + 32'h1;
      end
      if (input_signal_lost) begin
        signal_loss_flag <= 1'b1;
      end else if (cfg_q[`DPMC_W_CTRL][`DPMC_LOS_CLR_BIT]) begin
        signal_loss_flag <= 1'b0;
      end
    end
  end

  // Registered decode of configuration into control outputs
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prescale_div       <= 8'h01;
      loop1_fb_div       <= 15'h0004;
      vco0_feedback_div  <= 8'h14;
      vco1_feedback_div  <= 8'h14;
      vco_select         <= 1'b0;
      bank_a_div         <= 7'h01;
      bank_b_div         <= 7'h01;
      bank_c_div         <= 7'h01;
      sysref_div         <= 12'h040;
      bank_a_phase       <= 6'h00;
      bank_b_phase       <= 6'h00;
      bank_c_phase       <= 6'h00;
      sysref_out_en      <= 4'h0;
      sysref_periodic    <= 4'h0;
      sysref_as_clock    <= 4'h0;
      sysref_pulse_cnt   <= 4'h0;
      loop2_ref_is_input <= 1'b0;
      cleaned_ref_out_en <= 1'b1;
      holdover_active    <= 1'b0;
      vctrl_park_mid     <= 1'b0;
      pump_current_code  <= 6'h00;
      pump_current_ua    <= 11'h000;
      fault_status_pin_b <= 1'b1;
    end else begin
      // A zero pre-scaler would stop the loop, so it reads as 1
      prescale_div <= clamp8(cfg_q[`DPMC_W_LOOP1][7:0], 8'h01);
      loop1_fb_div <= (cfg_q[`DPMC_W_LOOP1][22:8] < 15'h0004) ?
                      15'h0004 : cfg_q[`DPMC_W_LOOP1][22:8];
      vco0_feedback_div <= clamp8(cfg_q[`DPMC_W_LOOP2][7:0], 8'h08);
      vco1_feedback_div <= clamp8(cfg_q[`DPMC_W_LOOP2][15:8], 8'h08);
      vco_select   <= cfg_q[`DPMC_W_LOOP2][`DPMC_VCO_SEL_BIT];
      bank_a_div   <= bank_ratio(cfg_q[`DPMC_W_BANK][4:0]);
      bank_b_div   <= bank_ratio(cfg_q[`DPMC_W_BANK][9:5]);
      bank_c_div   <= bank_ratio(cfg_q[`DPMC_W_BANK][14:10]);
      sysref_div   <= sref_ratio(cfg_q[`DPMC_W_BANK][18:15]);
      bank_a_phase <= cfg_q[`DPMC_W_PHASE][5:0];
      bank_b_phase <= cfg_q[`DPMC_W_PHASE][13:8];
      bank_c_phase <= cfg_q[`DPMC_W_PHASE][21:16];
      // Clock mode overrides sysref enable on the same output
      sysref_as_clock  <= cfg_q[`DPMC_W_SREF][11:8];
      sysref_out_en    <= cfg_q[`DPMC_W_SREF][3:0] & ~cfg_q[`DPMC_W_SREF][11:8];
      sysref_periodic  <= cfg_q[`DPMC_W_SREF][7:4];
      sysref_pulse_cnt <= cfg_q[`DPMC_W_SREF][15:12];
      loop2_ref_is_input <= cfg_q[`DPMC_W_CTRL][`DPMC_BYPASS_BIT];
      // No cleaned clock exists while the first loop is bypassed
      cleaned_ref_out_en <= ~cfg_q[`DPMC_W_CTRL][`DPMC_BYPASS_BIT];
      holdover_active <= input_signal_lost |
                         cfg_q[`DPMC_W_CTRL][`DPMC_HOLD_BIT];
      vctrl_park_mid  <= input_signal_lost |
                         cfg_q[`DPMC_W_CTRL][`DPMC_HOLD_BIT];
      pump_current_code <= cfg_q[`DPMC_W_CTRL][13:8];
      // 20 uA per step: code*16 + code*4
      pump_current_ua <= {1'b0, cfg_q[`DPMC_W_CTRL][13:8], 4'h0} +
                         {3'h0, cfg_q[`DPMC_W_CTRL][13:8], 2'h0};
      fault_status_pin_b <= ~signal_loss_flag;
    end
  end

  // The first-loop clock itself is analog; this input only exists for
  // parity with the pin and is not used by the control logic.
  wire unused_vcxo = vcxo_clk_in;
endmodule

// ---- shared/dpmc_defs.vh ----
`ifndef DPMC_DEFS_VH
`define DPMC_DEFS_VH

// Configuration word count and width
`define DPMC_NWORDS        8
`define DPMC_WBITS         32
`define DPMC_IDX_BITS      3

// SPI frame: 1 read flag, 3 address bits, 32 data bits
`define DPMC_FRAME_BITS    36

// Word 0: first loop dividers
`define DPMC_W_LOOP1       3'h0
`define DPMC_PRE_LSB       0
`define DPMC_FB1_LSB       8
// Word 1: second loop feedback dividers
`define DPMC_W_LOOP2       3'h1
`define DPMC_VCO0_LSB      0
`define DPMC_VCO1_LSB      8
`define DPMC_VCO_SEL_BIT   16
// Word 2: bank output divider codes (5 bits each) and sysref ratio code (4 bits)
`define DPMC_W_BANK        3'h2
`define DPMC_BANKA_LSB     0
`define DPMC_BANKB_LSB     5
`define DPMC_BANKC_LSB     10
`define DPMC_SREF_LSB      15
// Word 3: bank phase delay (6 bits each)
`define DPMC_W_PHASE       3'h3
// Word 4: sysref per-output mode
`define DPMC_W_SREF        3'h4
`define DPMC_SREF_EN_LSB   0
`define DPMC_SREF_PER_LSB  4
`define DPMC_SREF_CLK_LSB  8
`define DPMC_SREF_CNT_LSB  12
// Word 5: loop control
`define DPMC_W_CTRL        3'h5
`define DPMC_BYPASS_BIT    0
`define DPMC_HOLD_BIT      1
`define DPMC_PUMP_LSB      8
`define DPMC_LOS_CLR_BIT   16

// Reset values
`define DPMC_RST_LOOP1     32'h0000_0401
`define DPMC_RST_LOOP2     32'h0000_1414
`define DPMC_RST_ZERO      32'h0000_0000

// Loss of signal window, in ns
`define DPMC_LOS_TIME_NS   10000
`define DPMC_CLK_NS        10

`endif

// ---- logic/dpmc_spi_slave.v ----
`timescale 1ns/1ps
`include "dpmc_defs.vh"

// SPI slave: shifts in a frame while load enable is low and captures it
module dpmc_spi_slave #(
  parameter FRAME = `DPMC_FRAME_BITS
) (
  input  wire             clk_sys,
  input  wire             rst_b,
  input  wire             sck,
  input  wire             mosi,
  input  wire             le_b,
  input  wire [31:0]      rd_data,
  output reg              miso,
  output reg              wr_stb,
  output reg  [2:0]       wr_idx,
  output reg  [31:0]      wr_data,
  output wire [2:0]       rd_idx
);
  reg [2:0]       sck_s_q;
  reg [2:0]       le_s_q;
  reg [1:0]       mosi_s_q;
  reg [FRAME-1:0] sh_q;
  reg [5:0]       cnt_q;
  reg [31:0]      out_q;

  wire sck_rise = sck_s_q[1] & ~sck_s_q[2];
  wire sck_fall = ~sck_s_q[1] & sck_s_q[2];
  wire le_rise  = le_s_q[1] & ~le_s_q[2];
  wire active   = ~le_s_q[1];

  // Address is known after four bits; read data is latched then
  assign rd_idx = sh_q[2:0];

  // Pins are async to clk_sys, so two stages before use
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sck_s_q  <= 3'h0;
      le_s_q   <= 3'h7;
      mosi_s_q <= 2'h0;
    end else begin
      sck_s_q  <= {sck_s_q[1:0], sck};
      le_s_q   <= {le_s_q[1:0], le_b};
      mosi_s_q <= {mosi_s_q[0], mosi};
    end
  end

  // Shift, read-back and write capture
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sh_q    <= {FRAME{1'b0}};
      cnt_q   <= 6'h00;
      out_q   <= 32'h0000_0000;
      miso    <= 1'b0;
      wr_stb  <= 1'b0;
      wr_idx  <= 3'h0;
      wr_data <= 32'h0000_0000;
    end else begin
      wr_stb <= 1'b0;
      if (!active) begin
        cnt_q <= 6'h00;
      end
      if (active && sck_rise) begin
        sh_q  <= {sh_q[FRAME-2:0], mosi_s_q[1]};
        cnt_q <= cnt_q + 6'h01;
      end
      // Read-back word is loaded once the header is complete
      if (active && sck_fall) begin
        if (cnt_q == 6'h04) begin
          out_q <= {rd_data[30:0], 1'b0};
          miso  <= rd_data[31];
        end else begin
          out_q <= {out_q[30:0], 1'b0};
          miso  <= out_q[31];
        end
      end
      // Short frames are dropped rather than half applied
      if (le_rise && cnt_q == FRAME[5:0] && !sh_q[FRAME-1]) begin
        wr_stb  <= 1'b1;
        wr_idx  <= sh_q[34:32];
        wr_data <= sh_q[31:0];
      end
    end
  end
endmodule

// ---- test/dpmc_core_asserts.sv ----
`timescale 1ns/1ps

// Pin checker; quiet_q counts cycles since the reference last moved
module dpmc_core_asserts #(
  parameter LOS_CYCLES = 1000
) (
  input wire        clk_sys,
  input wire        rst_b,
  input wire        ref_clk_in,
  input wire [7:0]  prescale_div,
  input wire [14:0] loop1_fb_div,
  input wire [7:0]  vco0_feedback_div,
  input wire [7:0]  vco1_feedback_div,
  input wire [11:0] sysref_div,
  input wire        loop2_ref_is_input,
  input wire        holdover_active,
  input wire        vctrl_park_mid,
  input wire [5:0]  pump_current_code,
  input wire [10:0] pump_current_ua,
  input wire        signal_loss_flag,
  input wire        fault_status_pin_b
);
  reg        ref_last_q;
  reg [15:0] quiet_q;

  // Saturates so a long parked reference never wraps to zero
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ref_last_q <= 1'b0;
      quiet_q    <= 16'h0000;
    end else begin
      ref_last_q <= ref_clk_in;
      if (ref_clk_in != ref_last_q) quiet_q <= 16'h0000;
      else if (quiet_q != 16'hffff) quiet_q <= quiet_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Loss event and the hold-over that follows it
  sequence s_loss_up;
    $rose(signal_loss_flag);
  endsequence
  sequence s_hold_soon;
    ##[0:2] holdover_active;
  endsequence

  chk_fault_pin_follow: assert property (
    fault_status_pin_b == !$past(signal_loss_flag)) else $error("fault pin wrong");
  chk_loss_holdover: assert property (s_loss_up |-> s_hold_soon)
    else $error("loss without hold-over");
  chk_hold_park_mid: assert property (holdover_active |-> ##[0:2] vctrl_park_mid)
    else $error("hold-over not parked");
  chk_pump_step: assert property (
    $stable(pump_current_code) |-> pump_current_ua == pump_current_code * 11'd20)
    else $error("pump current wrong");
  chk_bypass_no_loss: assert property (
    loop2_ref_is_input && !signal_loss_flag |=> !signal_loss_flag) else $error("loss in bypass");
  chk_loss_not_early: assert property (s_loss_up |-> quiet_q >= LOS_CYCLES - 2)
    else $error("loss too early");
  chk_loss_in_time: assert property (
    quiet_q == LOS_CYCLES + 8 && !loop2_ref_is_input |-> signal_loss_flag)
    else $error("loss too late");
  chk_loop1_floor: assert property (
    prescale_div != 8'h00 && loop1_fb_div >= 15'h0004) else $error("loop1 ratio low");
  chk_vco_floor: assert property (
    vco0_feedback_div >= 8'h08 && vco1_feedback_div >= 8'h08) else $error("vco ratio low");
  chk_sysref_ratio: assert property (sysref_div inside {12'h040, 12'h080, 12'h0c0,
    12'h100, 12'h180, 12'h200, 12'h300, 12'h400, 12'h600, 12'h800}) else $error("sysref ratio");
endmodule

bind dpmc_core dpmc_core_asserts #(.LOS_CYCLES(LOS_CYCLES)) u_asserts (
  .clk_sys, .rst_b, .ref_clk_in, .prescale_div, .loop1_fb_div, .vco0_feedback_div,
  .vco1_feedback_div, .sysref_div, .loop2_ref_is_input, .holdover_active, .vctrl_park_mid,
  .pump_current_code, .pump_current_ua, .signal_loss_flag, .fault_status_pin_b);

// ---- test/dpmc_spi_host.sv ----
`timescale 1ns/1ps

// Serial host: sck at clk/12, parked low between frames
module dpmc_spi_host (
  input  wire clk_sys,
  output reg  spi_sck,
  output reg  spi_mosi,
  output reg  spi_le_b,
  input  wire spi_miso
);
  initial begin
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
    spi_le_b = 1'b1;
  end

  // One whole 36-bit frame, MSB first; read bits taken as sck rises
  task xfer(input [35:0] f, output [31:0] rd);
    integer i;
    begin
      rd = 32'h0;
      @(posedge clk_sys) spi_le_b <= 1'b0;
      for (i = 35; i >= 0; i = i - 1) begin
        spi_mosi <= f[i];
        repeat (6) @(posedge clk_sys);
        spi_sck <= 1'b1;
        if (i < 32) rd = {rd[30:0], spi_miso};
        repeat (6) @(posedge clk_sys);
        spi_sck <= 1'b0;
      end
      repeat (6) @(posedge clk_sys);
      spi_le_b <= 1'b1;
      spi_mosi <= 1'b0;  // Pin is pulled low once released
      repeat (12) @(posedge clk_sys);  // Gap also covers output decode latency
    end
  endtask
endmodule

// ---- test/dual_pll_divider_mode_control_test.sv ----
`timescale 1ns/1ps

module dual_pll_divider_mode_control_test;
  localparam LOSC = 20;
  localparam [125:0] BANK_T = {7'h60, 7'h50, 7'h40, 7'h30, 7'h28, 7'h20, 7'h18, 7'h14,
    7'h10, 7'h0c, 7'h0a, 7'h08, 7'h06, 7'h05, 7'h04, 7'h03, 7'h02, 7'h01};
  localparam [119:0] SREF_T = {12'h800, 12'h600, 12'h400, 12'h300, 12'h200, 12'h180,
    12'h100, 12'h0c0, 12'h080, 12'h040};
  reg         clk_sys = 1'b0;
  reg         rst_b = 1'b0;
  reg         ref_clk_in = 1'b0;
  reg         ref_run = 1'b1;
  reg  [31:0] seed = 32'h410e8888;
  reg  [31:0] w, w3, rd;
  reg  [7:0]  p;
  integer     bad_count = 0;
  integer     samples_checked = 0;
  integer     k;
  wire        spi_sck, spi_mosi, spi_le_b, spi_miso, vco_select, loop2_ref_is_input;
  wire        cleaned_ref_out_en, holdover_active, vctrl_park_mid, signal_loss_flag;
  wire        fault_status_pin_b;
  wire [7:0]  prescale_div, vco0_feedback_div, vco1_feedback_div;
  wire [14:0] loop1_fb_div;
  wire [6:0]  bank_a_div, bank_b_div, bank_c_div;
  wire [11:0] sysref_div;
  wire [5:0]  bank_a_phase, bank_b_phase, bank_c_phase, pump_current_code;
  wire [3:0]  sysref_out_en, sysref_periodic, sysref_as_clock, sysref_pulse_cnt;
  wire [10:0] pump_current_ua;
  // Grouped views of the outputs per config word; only w3v and w4v keep its bit layout
  wire [22:0] w0v = {prescale_div, loop1_fb_div};
  wire [16:0] w1v = {vco0_feedback_div, vco1_feedback_div, vco_select};
  wire [32:0] w2v = {bank_a_div, bank_b_div, bank_c_div, sysref_div};
  wire [21:0] w3v = {bank_c_phase, 2'b00, bank_b_phase, 2'b00, bank_a_phase};
  wire [15:0] w4v = {sysref_pulse_cnt, sysref_as_clock, sysref_periodic, sysref_out_en};
  wire [19:0] w5v = {pump_current_code, pump_current_ua, loop2_ref_is_input,
    holdover_active, vctrl_park_mid};
  wire [3:0]  stv = {fault_status_pin_b, signal_loss_flag, holdover_active, vctrl_park_mid};

  always #5 clk_sys = ~clk_sys;
  // Reference toggles unless a test parks it
  always @(posedge clk_sys) if (ref_run) ref_clk_in <= ~ref_clk_in;

  dpmc_core #(.LOS_CYCLES(LOSC)) dut (
    .clk_sys, .rst_b, .spi_sck, .spi_mosi, .spi_le_b, .spi_miso, .ref_clk_in,
    .vcxo_clk_in(1'b0), .prescale_div, .loop1_fb_div, .vco0_feedback_div,
    .vco1_feedback_div, .vco_select, .bank_a_div, .bank_b_div, .bank_c_div, .sysref_div,
    .bank_a_phase, .bank_b_phase, .bank_c_phase, .sysref_out_en, .sysref_periodic,
    .sysref_as_clock, .sysref_pulse_cnt, .loop2_ref_is_input, .cleaned_ref_out_en,
    .holdover_active, .vctrl_park_mid, .pump_current_code, .pump_current_ua,
    .signal_loss_flag, .fault_status_pin_b);
  dpmc_spi_host host (.clk_sys, .spi_sck, .spi_mosi, .spi_le_b, .spi_miso);

  function [6:0] nb(input integer c);
    nb = BANK_T[c*7 +: 7];
  endfunction
  function [11:0] ns(input integer c);
    ns = SREF_T[c*12 +: 12];
  endfunction

  task chk(input string nm, input [63:0] e, input [63:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("Error %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Settle margin so outputs are read after the edge's updates land
  task wr(input [2:0] a, input [31:0] d);
    begin
      host.xfer({1'b0, a, d}, rd);
      #1;
    end
  endtask
  task rdc(input [2:0] a, input [31:0] e);
    begin
      host.xfer({1'b1, a, 32'h0}, rd);
      chk("readback", e, rd);
    end
  endtask
  task park(input [31:0] ctl);
    begin
      wr(3'h5, ctl);
      ref_run <= 1'b0;
      repeat (LOSC + 10) @(posedge clk_sys);
      #1;
    end
  endtask
  task stop_test;
    begin
      if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask

  // Watchdog sized well above the ~60 frames of the sequence
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count = bad_count + 1;
    stop_test;
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("rst_w0", {8'h01, 15'h0004}, w0v);
    chk("rst_w1", {8'h14, 8'h14, 1'b0}, w1v);
    chk("rst_w2", {7'h01, 7'h01, 7'h01, 12'h040}, w2v);
    chk("rst_st", 5'h18, {cleaned_ref_out_en, stv});
    for (k = 0; k < 8; k = k + 1) rdc(k[2:0], k == 0 ? 32'h401 : k == 1 ? 32'h1414 : 32'h0);
    // Loop 1: zero and short ratios clamp, then top and random ratios
    for (k = 0; k < 5; k = k + 1) begin
      w = $random(seed);
      p = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : w[7:0] % 8'hff + 8'h01;
      w = {9'h0, (k == 0) ? 15'h0003 : (k == 1) ? 15'h7fff : w[22:8] % 15'h7ffc + 15'h0004, p};
      wr(3'h0, w);
      chk("w0", {p | {7'h0, p == 8'h00}, (k == 0) ? 15'h0004 : w[22:8]}, w0v);
      if (k != 0) rdc(3'h0, w);
    end
    for (k = 0; k < 4; k = k + 1) begin
      w = $random(seed);
      p = (k == 0) ? 8'h07 : w[7:0] % 8'hf8 + 8'h08;
      w = {15'h0, w[16], (k == 1) ? 8'hff : w[15:8] % 8'hf8 + 8'h08, p};
      wr(3'h1, w);
      chk("w1", {(p < 8'h08) ? 8'h08 : p, w[15:8], w[16]}, w1v);
    end
    // Every bank ratio and every sysref ratio at least once
    for (k = 0; k < 18; k = k + 1) begin
      p = $random(seed) & 8'h0f;
      w = {13'h0, 4'(k % 10), p[4:0], 5'(17 - k), 5'(k)};
      wr(3'h2, w);
      chk("w2", {nb(k), nb(17 - k), nb(p), ns(k % 10)}, w2v);
    end
    for (k = 0; k < 3; k = k + 1) begin
      w3 = $random(seed) & 32'h003f3f3f;
      wr(3'h3, w3);
      chk("w3", w3[21:0], w3v);
      w = $random(seed) & 32'h0000ffff;
      wr(3'h4, w);
      chk("w4", {w[15:4], w[3:0] & ~w[11:8]}, w4v);
    end
    // A read frame carries data yet must not write
    host.xfer({1'b1, 3'h3, ~w3}, rd);
    #1;
    chk("rd_only", w3, rd);
    chk("w3_kept", w3[21:0], w3v);
    for (k = 0; k < 4; k = k + 1) begin
      p = (k == 0) ? 8'h3f : $random(seed) & 8'h3f;
      wr(3'h5, {18'h0, p[5:0], 6'h0, k[1:0]});
      chk("w5", {p[5:0], p[5:0] * 11'd20, k[0], k[1], k[1]}, w5v);
      chk("cleaned", {63'h0, ~k[0]}, {63'h0, cleaned_ref_out_en});
    end
    // Loss is sticky after the reference returns, until cleared
    park(32'h0);
    chk("loss", 4'h7, stv);
    ref_run <= 1'b1;
    wr(3'h5, 32'h0);
    chk("sticky", 4'h4, stv);
    wr(3'h5, 32'h0001_0000);
    wr(3'h5, 32'h0);
    chk("cleared", 4'h8, stv);
    park(32'h1);
    chk("bypass", 4'h8, stv);
    ref_run <= 1'b1;
    wr(3'h5, 32'h0);
    stop_test;
  end
endmodule
